// file: core/core_fault_debug_status.sv
/*
  Flag computation, fault status word and stack image, debug halt
  entry and system register read/write commands, on one clock.
  Assumes the serial debug shifter outside delivers whole command and
  operand words over the Avalon-MM slave; debug request pins are async.
*/
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - Logic ops: NZ from result, VC clear
// - Divide: NZ result, V overflow, C clear
// - Decimal add: C carry, Z sticky clear
// - Released fault word bit layout
// - Pending trace and breaks recorded
// - Stack next address, state, fault, data
// - Classify restartable versus released faults
// - Restartable fault aborts instruction immediately
// - Undo postincrement/predecrement address changes
// - Restartable fault word bit layout
// - Restartable word trace flag zero
// - Restartable word keeps break flags
// - Atomic flag and direction on atomics
// - Ignore flushed prefetch breaks, take operand
// - Five sources enter debug halt
// - Halt stops fetches, serial commands only
// - Debug enabled only if pin at reset
// - Register read returns zero-extended 32 bits
// - Register select code decode
// - Write command pattern and select field
// - Narrow registers take least significant word
// - Write returns command complete status
module core_fault_debug_status
  import fault_debug_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [2:0] flag_op_i,
  input wire logic [DATA_W-1:0] result_i,
  input wire logic overflow_i,
  input wire logic dec_carry_i,
  input wire logic [4:0] flags_in_i,
  output logic [4:0] flags_o,
  input wire logic bus_fault_i,
  input wire logic [2:0] cycle_kind_i,
  input wire logic cycle_write_i,
  input wire logic cycle_long_i,
  input wire logic [1:0] cycle_size_i,
  input wire logic [2:0] cycle_space_i,
  input wire logic trace_pend_i,
  input wire logic [1:0] break_pend_i,
  input wire logic [DATA_W-1:0] next_pc_i,
  input wire logic [DATA_W-1:0] fault_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [DATA_W-1:0] addr_delta_i,
  input wire logic [2:0] ea_reg_i,
  output logic [15:0] fault_status_word_o,
  output logic released_fault_o,
  output logic abort_o,
  output logic restore_o,
  output logic [2:0] restore_reg_o,
  output logic [DATA_W-1:0] restore_delta_o,
  output logic [DATA_W-1:0] stack_pc_o,
  output logic [15:0] stack_psw_o,
  output logic [DATA_W-1:0] stack_addr_o,
  output logic [DATA_W-1:0] stack_data_o,
  input wire logic break_request_pin_i,
  input wire logic periph_break_i,
  input wire logic debug_entry_opcode_i,
  input wire logic catastrophic_i,
  input wire logic break_prefetch_i,
  input wire logic break_flushed_i,
  input wire logic break_operand_i,
  output logic break_ack_o,
  output logic break_exc_o,
  output logic debug_halt_state_o,
  output logic fetch_enable_o,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic break_request_pin_s1, break_request_pin_s2, pbrk_s1, pbrk_s2;
  always_ff @(posedge clk_i) begin
    break_request_pin_s1 <= break_request_pin_i;
    break_request_pin_s2 <= break_request_pin_s1;
    pbrk_s1 <= periph_break_i;
    pbrk_s2 <= pbrk_s1;
  end

  // ----------------------------------------
  // Condition flags
  // ----------------------------------------
  logic res_zero, res_neg;
  logic [4:0] next_flags;
  assign res_zero = (result_i == '0);
  assign res_neg = result_i[DATA_W-1];
  always_comb begin
    next_flags = flags_in_i;
    unique case (flag_op_t'(flag_op_i))
      OP_LOGIC: begin
        next_flags[FLAG_N] = res_neg;
        next_flags[FLAG_Z] = res_zero;
        next_flags[FLAG_V] = 1'b0;
        next_flags[FLAG_C] = 1'b0;
      end
      OP_DIV, OP_MUL: begin
        next_flags[FLAG_N] = res_neg;
        next_flags[FLAG_Z] = res_zero;
        next_flags[FLAG_V] = overflow_i;
        next_flags[FLAG_C] = 1'b0;
      end
      OP_DEC_ADD: begin
        // N and V undefined; left as they were
        next_flags[FLAG_C] = dec_carry_i;
        next_flags[FLAG_X] = dec_carry_i;
        next_flags[FLAG_Z] = flags_in_i[FLAG_Z] & res_zero;
      end
      default: next_flags = flags_in_i;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) flags_o <= 5'h0_0;
    else flags_o <= next_flags;
  end
  a_logic_flags: assert property (@(posedge clk_i) disable iff (srst_i)
    flag_op_i == OP_LOGIC |=> flags_o[FLAG_V:FLAG_C] == 2'h0 && flags_o[FLAG_X] == $past(flags_in_i[FLAG_X]))
    else $error("logic op flags wrong");
  a_div_flags: assert property (@(posedge clk_i) disable iff (srst_i)
    flag_op_i == OP_DIV |=> flags_o[FLAG_C] == 1'b0 && flags_o[FLAG_V] == $past(overflow_i))
    else $error("divide flags wrong");
  a_dec_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    flag_op_i == OP_DEC_ADD && !res_zero |=> !flags_o[FLAG_Z])
    else $error("decimal zero not cleared");

  // ----------------------------------------
  // Fault classification and status word
  // ----------------------------------------
  logic is_released, is_atomic;
  logic [15:0] rel_word, rst_word;
  // Plain operand writes are released; the final write of a move is too
  assign is_released = (cycle_kind_i == CYC_LAST_MOVE_WR) || (cycle_kind_i == CYC_OP_WRITE);
  assign is_atomic = (cycle_kind_i == CYC_ATOMIC);
  assign rel_word = {3'h0, trace_pend_i, break_pend_i, 1'b1, 3'h0, cycle_long_i,
                     cycle_size_i, cycle_space_i};
  assign rst_word = {4'h0, break_pend_i, 1'b0, is_atomic, cycle_kind_i == CYC_PREFETCH,
                     cycle_write_i, cycle_long_i, cycle_size_i, cycle_space_i};
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fault_status_word_o <= 16'h0000;
      released_fault_o <= 1'b0;
      stack_pc_o <= '0;
      stack_addr_o <= '0;
      stack_data_o <= '0;
      stack_psw_o <= 16'h0000;
    end else if (bus_fault_i) begin
      fault_status_word_o <= is_released ? rel_word : rst_word;
      released_fault_o <= is_released;
      stack_pc_o <= next_pc_i;
      stack_psw_o <= {11'h000, flags_o};
      stack_addr_o <= fault_addr_i;
      stack_data_o <= wr_data_i;
    end
  end
  // Abort and register restore are combinational so the sequencer stops now
  assign abort_o = bus_fault_i && !is_released;
  assign restore_o = abort_o;
  assign restore_reg_o = ea_reg_i;
  assign restore_delta_o = addr_delta_i;
  a_rel_word: assert property (@(posedge clk_i) disable iff (srst_i)
    bus_fault_i && is_released |=> fault_status_word_o[FSW_REL] && fault_status_word_o[15:13] == 3'h0
      && fault_status_word_o[FSW_TRACE] == $past(trace_pend_i))
    else $error("released word wrong");
  a_rst_word: assert property (@(posedge clk_i) disable iff (srst_i)
    bus_fault_i && !is_released |=> !fault_status_word_o[FSW_TRACE] && !fault_status_word_o[FSW_REL]
      && fault_status_word_o[FSW_B1:FSW_B0] == $past(break_pend_i))
    else $error("restartable word wrong");
  a_atomic_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    bus_fault_i && is_atomic |=> fault_status_word_o[FSW_ATOMIC]
      && fault_status_word_o[FSW_DIR] == $past(cycle_write_i))
    else $error("atomic flag wrong");

  // ----------------------------------------
  // Debug enable capture and halt entry
  // ----------------------------------------
  logic dbg_enabled, in_reset_d, resume_req, halt_req;
  always_ff @(posedge clk_i) begin
    in_reset_d <= srst_i;
    // Sampled while reset is held; latched at release
    if (srst_i) dbg_enabled <= break_request_pin_s2;
  end
  assign break_ack_o = break_operand_i || (break_prefetch_i && !break_flushed_i);
  assign break_exc_o = break_ack_o && !dbg_enabled;
  assign halt_req = dbg_enabled && (break_request_pin_s2 || pbrk_s2 || debug_entry_opcode_i
                    || catastrophic_i || break_ack_o);
  always_ff @(posedge clk_i) begin
    if (srst_i) debug_halt_state_o <= 1'b0;
    else if (halt_req) debug_halt_state_o <= 1'b1;
    else if (resume_req) debug_halt_state_o <= 1'b0;
  end
  assign fetch_enable_o = !debug_halt_state_o && !in_reset_d;
  a_halt_nofetch: assert property (@(posedge clk_i) disable iff (srst_i)
    debug_halt_state_o |-> !fetch_enable_o)
    else $error("fetch during halt");
  a_no_enable: assert property (@(posedge clk_i) disable iff (srst_i)
    !dbg_enabled && !debug_halt_state_o |=> !debug_halt_state_o)
    else $error("halt without enable");

  // ----------------------------------------
  // System registers
  // ----------------------------------------
  logic [DATA_W-1:0] sr_ret, sr_cur, sr_scratch, sr_fault, sr_vbase, sr_usp, sr_ssp;
  logic [15:0] sr_psw;
  logic [2:0] sr_src, sr_dst;
  logic [31:0] operand, result, cmd;
  logic cmd_done, cmd_bad;
  logic [3:0] sel;
  logic is_wr_cmd, is_rd_cmd, do_cmd;
  logic [31:0] rd_mux;
  assign sel = cmd[3:0];
  assign is_wr_cmd = cmd[15:4] == WR_SYS_PATTERN;
  assign is_rd_cmd = cmd[15:4] == RD_SYS_PATTERN;
  // Commands only act while halted; the serial side is the only path in
  assign do_cmd = avs_write && avs_address == ADDR_CMD && debug_halt_state_o;
  always_comb begin
    unique case (sel)
      SEL_RET: rd_mux = sr_ret;
      SEL_CUR: rd_mux = sr_cur;
      SEL_SCRATCH: rd_mux = sr_scratch;
      SEL_FAULT: rd_mux = sr_fault;
      SEL_VBASE: rd_mux = sr_vbase;
      SEL_PSW: rd_mux = {16'h0000, sr_psw};
      SEL_USP: rd_mux = sr_usp;
      SEL_SSP: rd_mux = sr_ssp;
      SEL_SRC: rd_mux = {29'h0000_0000, sr_src};
      SEL_DST: rd_mux = {29'h0000_0000, sr_dst};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      {sr_ret, sr_cur, sr_scratch, sr_fault, sr_vbase, sr_usp, sr_ssp} <= '0;
      sr_psw <= 16'h0000;
      sr_src <= 3'h0;
      sr_dst <= 3'h0;
      cmd <= 32'h0000_0000;
      operand <= 32'h0000_0000;
      result <= 32'h0000_0000;
      cmd_done <= 1'b0;
      cmd_bad <= 1'b0;
    end else begin
      if (avs_write && avs_address == ADDR_OPERAND) operand <= avs_writedata;
      if (bus_fault_i) sr_fault <= fault_addr_i;
      if (do_cmd) begin
        cmd <= avs_writedata;
      end
      if (do_cmd && avs_writedata[15:4] == WR_SYS_PATTERN) begin
        unique case (avs_writedata[3:0])
          SEL_RET: sr_ret <= operand;
          SEL_CUR: sr_cur <= operand;
          SEL_SCRATCH: sr_scratch <= operand;
          SEL_FAULT: sr_fault <= operand;
          SEL_VBASE: sr_vbase <= operand;
          SEL_PSW: sr_psw <= operand[15:0];
          SEL_USP: sr_usp <= operand;
          SEL_SSP: sr_ssp <= operand;
          SEL_SRC: sr_src <= operand[2:0];
          SEL_DST: sr_dst <= operand[2:0];
          default: sr_scratch <= sr_scratch;
        endcase
        cmd_done <= 1'b1;
        cmd_bad <= 1'b0;
      end else if (do_cmd && avs_writedata[15:4] == RD_SYS_PATTERN) begin
        cmd_done <= 1'b1;
        cmd_bad <= 1'b0;
      end else if (do_cmd) begin
        cmd_done <= 1'b0;
        cmd_bad <= 1'b1;
      end else if (avs_read && avs_address == ADDR_STATUS) begin
        cmd_done <= 1'b0;
      end
      if (is_rd_cmd) result <= rd_mux;
    end
  end
  a_wr_complete: assert property (@(posedge clk_i) disable iff (srst_i)
    do_cmd && avs_writedata[15:4] == WR_SYS_PATTERN |=> cmd_done && !cmd_bad)
    else $error("write not completed");
  a_psw_narrow: assert property (@(posedge clk_i) disable iff (srst_i)
    do_cmd && avs_writedata == {16'h0000, WR_SYS_PATTERN, SEL_PSW} |=> sr_psw == $past(operand[15:0]))
    else $error("narrow write wrong");
  assign resume_req = avs_write && avs_address == ADDR_CTRL && avs_writedata[CTRL_RESUME];

  // ----------------------------------------
  // Avalon-MM slave, zero wait states on writes, one on reads
  // ----------------------------------------
  logic [31:0] next_readdata;
  always_comb begin
    unique case (avs_address)
      ADDR_CTRL: next_readdata = 32'h0000_0000;
      ADDR_STATUS: next_readdata = {28'h000_0000, cmd_bad, cmd_done, dbg_enabled, debug_halt_state_o};
      ADDR_CMD: next_readdata = cmd;
      ADDR_OPERAND: next_readdata = operand;
      ADDR_RESULT: next_readdata = result;
      ADDR_FSW: next_readdata = {16'h0000, fault_status_word_o};
      default: next_readdata = BAD_READ;
    endcase
  end
  // Readdata registered; waitrequest holds the first cycle of each read
  logic rd_phase;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_phase <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_phase <= avs_read && !rd_phase;
      avs_readdata <= next_readdata;
    end
  end
  assign avs_waitrequest = avs_read && !rd_phase;
endmodule : core_fault_debug_status

// file: core/fault_debug_pkg.sv
/*
  Constants for the fault status, flag and debug block.
  Assumes a 125 MHz core clock and a synchronous active-high reset.
*/
package fault_debug_pkg;
  // ----------------------------------------
  // Flag operation classes
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_LOGIC = 3'h0,
    OP_DIV = 3'h1,
    OP_MUL = 3'h2,
    OP_DEC_ADD = 3'h3,
    OP_NONE = 3'h4
  } flag_op_t;
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_X = 4;
  // ----------------------------------------
  // Fault status word layout
  // ----------------------------------------
  localparam int FSW_TRACE = 12;
  localparam int FSW_B1 = 11;
  localparam int FSW_B0 = 10;
  localparam int FSW_REL = 9;
  localparam int FSW_ATOMIC = 8;
  localparam int FSW_FETCH = 7;
  localparam int FSW_DIR = 6;
  localparam int FSW_LONG = 5;
  localparam int FSW_SIZE_LO = 3;
  localparam int FSW_SPACE_CODE_FIELD_LO = 0;
  // ----------------------------------------
  // Bus cycle kinds of a faulted access
  // ----------------------------------------
  typedef enum logic [2:0] {
    CYC_PREFETCH = 3'h0,
    CYC_OP_READ = 3'h1,
    CYC_OP_WRITE = 3'h2,
    CYC_ATOMIC = 3'h3,
    CYC_PMOVE = 3'h4,
    CYC_LAST_MOVE_WR = 3'h5
  } cycle_kind_t;
  // ----------------------------------------
  // System register selects
  // ----------------------------------------
  localparam logic [3:0] SEL_RET = 4'h0;
  localparam logic [3:0] SEL_CUR = 4'h1;
  localparam logic [3:0] SEL_SCRATCH = 4'h8;
  localparam logic [3:0] SEL_FAULT = 4'h9;
  localparam logic [3:0] SEL_VBASE = 4'hA;
  localparam logic [3:0] SEL_PSW = 4'hB;
  localparam logic [3:0] SEL_USP = 4'hC;
  localparam logic [3:0] SEL_SSP = 4'hD;
  localparam logic [3:0] SEL_SRC = 4'hE;
  localparam logic [3:0] SEL_DST = 4'hF;
  localparam logic [11:0] WR_SYS_PATTERN = 12'h248;
  localparam logic [11:0] RD_SYS_PATTERN = 12'h249;
  // ----------------------------------------
  // Register bus map (word offsets x4)
  // ----------------------------------------
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h04;
  localparam logic [5:0] ADDR_CMD = 6'h08;
  localparam logic [5:0] ADDR_OPERAND = 6'h0C;
  localparam logic [5:0] ADDR_RESULT = 6'h10;
  localparam logic [5:0] ADDR_FSW = 6'h14;
  localparam logic [31:0] BAD_READ = 32'h0000_0000;
  localparam int CTRL_RESUME = 0;
  localparam int ST_HALT = 0;
  localparam int ST_ENABLED = 1;
  localparam int ST_DONE = 2;
  localparam int ST_BADCMD = 3;
endpackage : fault_debug_pkg

// file: tb/dev_system_model.sv
/*
  Development system model: Avalon-MM master for debug commands, break pin.
  Assumes the block answers reads through waitrequest on clk_i.
*/
`timescale 1ns/1ns
module dev_system_model
  import fault_debug_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  output logic [5:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  input wire logic avs_waitrequest_i,
  output logic break_request_pin_o
);
  logic want_debug = 1'b1;
  logic ext_break = 1'b0;
  initial begin
    avs_address_o = '0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = '0;
    break_request_pin_o = 1'b0;
  end
  // ----------------------------------------
  // Break pin: held during reset to arm debug
  // ----------------------------------------
  always @(posedge clk_i) break_request_pin_o <= srst_i ? want_debug : ext_break;
  task automatic set_debug(input logic v);
    want_debug = v;
  endtask : set_debug
  task automatic external_break(input logic v);
    ext_break = v;
  endtask : external_break
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Random idle gap so the block sees prompt and slow hosts
  task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
    repeat ($urandom_range(2)) @(posedge clk_i);
    @(posedge clk_i);
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_write_o <= 1'b1;
    @(posedge clk_i);
    while (avs_waitrequest_i) @(posedge clk_i);
    avs_write_o <= 1'b0;
    avs_address_o <= ~a;
    avs_writedata_o <= ~d;
  endtask : bus_write
  task automatic bus_read(input logic [5:0] a);
    repeat ($urandom_range(2)) @(posedge clk_i);
    @(posedge clk_i);
    avs_address_o <= a;
    avs_read_o <= 1'b1;
    @(posedge clk_i);
    while (avs_waitrequest_i) @(posedge clk_i);
    avs_read_o <= 1'b0;
    avs_address_o <= ~a;
  endtask : bus_read
  // Operand always goes as a full long word
  task automatic wr_sys(input logic [3:0] sel, input logic [31:0] v);
    bus_write(ADDR_OPERAND, v);
    bus_write(ADDR_CMD, {16'h0000, WR_SYS_PATTERN, sel});
  endtask : wr_sys
  task automatic rd_sys(input logic [3:0] sel);
    bus_write(ADDR_CMD, {16'h0000, RD_SYS_PATTERN, sel});
  endtask : rd_sys
endmodule : dev_system_model

// file: tb/test_core_fault_debug_status.sv
/*
  Self-checking bench: flags, fault words, debug halt and register commands.
  Assumes the hand-over timing: registered outputs one cycle after inputs.
*/
`timescale 1ns/1ns
module test_core_fault_debug_status;
  import fault_debug_pkg::*;
  typedef struct {
    logic [127:0] e;
    logic [127:0] m;
  } note_t;
  logic clk_i = 1'b0, srst_i = 1'b1, overflow_i = 1'b0, dec_carry_i = 1'b0, bus_fault_i = 1'b0;
  logic cycle_write_i = 1'b0, cycle_long_i = 1'b0, trace_pend_i = 1'b0, periph_break_i = 1'b0;
  logic debug_entry_opcode_i = 1'b0, catastrophic_i = 1'b0;
  logic break_prefetch_i = 1'b0, break_flushed_i = 1'b0, break_operand_i = 1'b0;
  logic [2:0] flag_op_i = OP_NONE, cycle_kind_i = '0, cycle_space_i = '0, ea_reg_i = '0, restore_reg_o;
  logic [31:0] result_i = '0, next_pc_i = '0, fault_addr_i = '0, wr_data_i = '0, addr_delta_i = '0;
  logic [4:0] flags_in_i = '0, flags_o;
  logic [1:0] cycle_size_i = '0, break_pend_i = '0;
  logic [15:0] fault_status_word_o, stack_psw_o;
  logic released_fault_o, abort_o, restore_o, break_ack_o, break_exc_o, debug_halt_state_o, fetch_enable_o;
  logic [31:0] restore_delta_o, stack_pc_o, stack_addr_o, stack_data_o, avs_writedata, avs_readdata;
  logic [5:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, break_request_pin;
  logic [2:0] probe = '0, pk = '0;
  note_t q[3][$];
  int fails = 0, cmp_count = 0;
  logic [3:0] sels[10] = '{SEL_RET, SEL_CUR, SEL_SCRATCH, SEL_FAULT, SEL_VBASE, SEL_PSW, SEL_USP, SEL_SSP,
                           SEL_SRC, SEL_DST};
  // Flags held steady during faults so the stacked state word is known
  localparam logic [4:0] PSW_FL = 5'h0A;
  core_fault_debug_status i_core_fault_debug_status (
    .clk_i(clk_i), .srst_i(srst_i), .flag_op_i(flag_op_i), .result_i(result_i), .overflow_i(overflow_i),
    .dec_carry_i(dec_carry_i), .flags_in_i(flags_in_i), .flags_o(flags_o), .bus_fault_i(bus_fault_i),
    .cycle_kind_i(cycle_kind_i), .cycle_write_i(cycle_write_i), .cycle_long_i(cycle_long_i),
    .cycle_size_i(cycle_size_i), .cycle_space_i(cycle_space_i), .trace_pend_i(trace_pend_i),
    .break_pend_i(break_pend_i), .next_pc_i(next_pc_i), .fault_addr_i(fault_addr_i), .wr_data_i(wr_data_i),
    .addr_delta_i(addr_delta_i), .ea_reg_i(ea_reg_i), .fault_status_word_o(fault_status_word_o),
    .released_fault_o(released_fault_o), .abort_o(abort_o), .restore_o(restore_o),
    .restore_reg_o(restore_reg_o), .restore_delta_o(restore_delta_o), .stack_pc_o(stack_pc_o),
    .stack_psw_o(stack_psw_o), .stack_addr_o(stack_addr_o), .stack_data_o(stack_data_o),
    .break_request_pin_i(break_request_pin), .periph_break_i(periph_break_i),
    .debug_entry_opcode_i(debug_entry_opcode_i), .catastrophic_i(catastrophic_i),
    .break_prefetch_i(break_prefetch_i), .break_flushed_i(break_flushed_i), .break_operand_i(break_operand_i),
    .break_ack_o(break_ack_o), .break_exc_o(break_exc_o), .debug_halt_state_o(debug_halt_state_o),
    .fetch_enable_o(fetch_enable_o), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  dev_system_model i_dev_system (
    .clk_i(clk_i), .srst_i(srst_i), .avs_address_o(avs_address), .avs_read_o(avs_read),
    .avs_write_o(avs_write), .avs_writedata_o(avs_writedata), .avs_waitrequest_i(avs_waitrequest),
    .break_request_pin_o(break_request_pin));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Notes and monitor
  // ----------------------------------------
  task automatic note(input int w, input logic [127:0] e, input logic [127:0] m = '1);
    note_t n;
    n.e = e;
    n.m = m;
    q[w].push_back(n);
  endtask : note
  task automatic cmp(input int w, input logic [127:0] got);
    note_t n;
    cmp_count++;
    if (q[w].size() == 0) begin
      fails++;
      $display("unexpected at %0t: result without note", $time);
    end else begin
      n = q[w].pop_front();
      if ((got & n.m) !== (n.e & n.m)) begin
        fails++;
        $display("unexpected at %0t: got %h want %h", $time, got & n.m, n.e & n.m);
      end
    end
  endtask : cmp
  // Registered results one cycle after the probe, combinational ones with it
  always @(negedge clk_i) begin
    if (pk == 3'h1) cmp(0, {123'h0, flags_o});
    if (pk == 3'h2) cmp(0, {released_fault_o, fault_status_word_o, stack_pc_o, stack_addr_o, stack_data_o});
    if (pk == 3'h2) cmp(2, stack_psw_o);
    if (pk == 3'h3) cmp(0, {debug_halt_state_o, fetch_enable_o});
    if (probe == 3'h2) cmp(1, {abort_o, restore_o, restore_reg_o, restore_delta_o});
    if (probe == 3'h4) cmp(1, {break_ack_o, break_exc_o});
  end
  always @(posedge clk_i) begin
    pk <= probe;
    if (avs_read && !avs_waitrequest) cmp(2, avs_readdata);
  end
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic flag_op(input logic [2:0] op);
    logic [31:0] r;
    logic ov, dc;
    logic [4:0] fi, ex, m;
    r = ($urandom_range(3) == 0) ? 32'h0000_0000 : ($urandom | 32'h0000_0001);
    ov = $urandom;
    dc = $urandom;
    fi = $urandom;
    m = 5'h1F;
    ex = {fi[FLAG_X], r[31], r == 0, ov, 1'b0};
    if (op == OP_LOGIC) ex[FLAG_V] = 1'b0;
    if (op == OP_NONE) ex = fi;
    if (op == OP_DEC_ADD) begin
      ex = {dc, 1'b0, fi[FLAG_Z] & (r == 0), 1'b0, dc};
      m = 5'h15;
    end
    @(posedge clk_i);
    flag_op_i <= op;
    result_i <= r;
    overflow_i <= ov;
    dec_carry_i <= dc;
    flags_in_i <= fi;
    probe <= 3'h1;
    note(0, ex, m);
  endtask : flag_op
  task automatic fault(input logic [2:0] k);
    logic w, l, t, rel;
    logic [1:0] b, s;
    logic [2:0] sp, rg;
    logic [31:0] pc, fa, wd, dl;
    logic [15:0] fsw;
    rel = (k == CYC_OP_WRITE) || (k == CYC_LAST_MOVE_WR);
    w = rel ? 1'b1 : ((k == CYC_ATOMIC) || (k == CYC_PMOVE)) ? 1'($urandom) : 1'b0;
    {l, t, b, s, sp, rg} = $urandom;
    {pc, fa, wd, dl} = {$urandom, $urandom, $urandom, $urandom};
    if (rel) fsw = {3'b000, t, b, 1'b1, 3'b000, l, s, sp};
    else fsw = {4'h0, b, 1'b0, k == CYC_ATOMIC, k == CYC_PREFETCH, w, l, s, sp};
    @(posedge clk_i);
    {bus_fault_i, cycle_kind_i, cycle_write_i, cycle_long_i, trace_pend_i, break_pend_i} <= {1'b1, k, w, l, t, b};
    {cycle_size_i, cycle_space_i, ea_reg_i} <= {s, sp, rg};
    {next_pc_i, fault_addr_i, wr_data_i, addr_delta_i} <= {pc, fa, wd, dl};
    probe <= 3'h2;
    note(0, {rel, fsw, pc, fa, wd}, ~{96'h0, {32{~rel}}});
    note(1, {~rel, ~rel, rg, dl}, rel ? {2'b11, 35'h0} : '1);
    note(2, {27'h0, PSW_FL});
  endtask : fault
  task automatic chk_halt(input logic h);
    @(posedge clk_i);
    probe <= 3'h3;
    note(0, {h, ~h});
    @(posedge clk_i);
    probe <= 3'h0;
  endtask : chk_halt
  task automatic drive_src(input int s, input logic v);
    case (s)
      0: i_dev_system.external_break(v);
      1: periph_break_i <= v;
      2: debug_entry_opcode_i <= v;
      3: catastrophic_i <= v;
      default: break_operand_i <= v;
    endcase
  endtask : drive_src
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    note(2, e, m);
    i_dev_system.bus_read(a);
  endtask : rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    #(8 * 20000);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    void'($urandom(62));
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    i_dev_system.bus_write(ADDR_CTRL, 32'h0000_0001);
    chk_halt(1'b0);
    for (int i = 0; i < 25; i++) flag_op(3'(i % 5));
    @(posedge clk_i);
    {probe, flag_op_i, flags_in_i} <= {3'h0, OP_NONE, PSW_FL};
    for (int i = 0; i < 18; i++) fault(3'(i % 6));
    @(posedge clk_i);
    {probe, bus_fault_i, flag_op_i} <= {3'h0, 1'b0, OP_NONE};
    for (int s = 0; s < 5; s++) begin
      @(posedge clk_i);
      drive_src(s, 1'b1);
      repeat (4) @(posedge clk_i);
      drive_src(s, 1'b0);
      repeat (3) @(posedge clk_i);
      chk_halt(1'b1);
      i_dev_system.bus_write(ADDR_CTRL, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      chk_halt(1'b0);
    end
    drive_src(2, 1'b1);
    @(posedge clk_i);
    drive_src(2, 1'b0);
    rd(ADDR_STATUS, 32'h0000_0003);
    foreach (sels[i]) begin
      v = $urandom;
      i_dev_system.wr_sys(sels[i], v);
      rd(ADDR_STATUS, 32'h0000_0007);
      i_dev_system.rd_sys(sels[i]);
      repeat (2) @(posedge clk_i);
      rd(ADDR_RESULT, (sels[i] == SEL_PSW) ? {16'h0000, v[15:0]} : (sels[i] >= SEL_SRC) ? {29'h0, v[2:0]} : v);
    end
    i_dev_system.bus_write(ADDR_CMD, 32'h0000_5550);
    rd(ADDR_STATUS, 32'h0000_000B, 32'hFFFF_FFFB);
    rd(6'h3C, BAD_READ);
    i_dev_system.set_debug(1'b0);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    drive_src(2, 1'b1);
    @(posedge clk_i);
    drive_src(2, 1'b0);
    chk_halt(1'b0);
    rd(ADDR_STATUS, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      {break_prefetch_i, break_flushed_i, break_operand_i} <= (i == 0) ? 3'b110 : (i == 1) ? 3'b100 : 3'b001;
      probe <= 3'h4;
      note(1, (i == 0) ? 2'b00 : 2'b11);
    end
    @(posedge clk_i);
    {probe, break_prefetch_i, break_flushed_i, break_operand_i} <= '0;
    repeat (4) @(posedge clk_i);
    summarize();
  end
endmodule : test_core_fault_debug_status
